// ---- pkg/dbgmc_cfg.svh ----
// constants of the debug port memory and register command logic
`ifndef DBGMC_CFG_SVH
`define DBGMC_CFG_SVH

// ----------------------------------------------------------------
// link framing
// ----------------------------------------------------------------
`define DBGMC_FRAME_BITS   5'h11
`define DBGMC_CNT_W        5

// ----------------------------------------------------------------
// command word fields
// ----------------------------------------------------------------
`define DBGMC_SIZE_HI      7
`define DBGMC_SIZE_LO      6
`define DBGMC_OP_WREG      8'h20
`define DBGMC_OP_WREG_SUB  4'h8
`define DBGMC_OP_READ      8'h19
`define DBGMC_OP_WRITE     8'h18
`define DBGMC_OP_DUMP      8'h1D
`define DBGMC_OP_FILL      8'h1C
`define DBGMC_CMD_GO       16'h0C00
`define DBGMC_CMD_NOP      16'h0000

// ----------------------------------------------------------------
// responses, status bit in bit 16
// ----------------------------------------------------------------
`define DBGMC_RSP_DONE     17'h0_FFFF
`define DBGMC_RSP_NRDY     17'h1_0000
`define DBGMC_RSP_ILL      17'h1_FFFF
`define DBGMC_RSP_BERR     17'h1_0001

`endif

// ---- pkg/dbgmc_pkg.sv ----
// types of the debug port memory and register command logic
package dbgmc_pkg;

    // ------------------------------------------------------------
    // operand size field
    // ------------------------------------------------------------
    typedef logic [1:0] dbgmc_size_t;
    localparam dbgmc_size_t DBGMC_SZ_BYTE = 2'h0;
    localparam dbgmc_size_t DBGMC_SZ_WORD = 2'h1;
    localparam dbgmc_size_t DBGMC_SZ_LONG = 2'h2;
    localparam dbgmc_size_t DBGMC_SZ_RSVD = 2'h3;

    // ------------------------------------------------------------
    // sequencer states and pending command kinds
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_CMD, ST_OPND, ST_MEM, ST_RES_LO
    } dbgmc_state_e;

    typedef enum logic [2:0] {
        K_WREG, K_READ, K_WRITE, K_DUMP, K_FILL
    } dbgmc_kind_e;

endpackage : dbgmc_pkg

// ---- src/dbgmc_serial.sv ----
// 17-bit serial shifter of the debug port, sampled by the core clock
`timescale 1ns/1ns
`include "dbgmc_cfg.svh"
module dbgmc_serial (
    // clock and reset
    input  wire logic        core_clk_i,
    input  wire logic        sys_rst_i,
    // link pins
    input  wire logic        dsclk_i,
    input  wire logic        dsi_i,
    output logic             dso_o,
    // core side
    input  wire logic [16:0] tx_word_i,
    output logic             rx_valid_o,
    output logic [15:0]      rx_word_o
);

    // ------------------------------------------------------------
    // synchronisers
    // ------------------------------------------------------------
    logic        clk_s1_q, clk_s2_q, clk_s3_q;
    logic        dat_s1_q, dat_s2_q;
    logic        rise, fall;
    logic [`DBGMC_CNT_W-1:0] cnt_q;
    logic [16:0] rx_sh_q;
    logic [15:0] tx_sh_q;

    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            clk_s1_q <= 1'b0;
            clk_s2_q <= 1'b0;
            clk_s3_q <= 1'b0;
            dat_s1_q <= 1'b0;
            dat_s2_q <= 1'b0;
        end else begin
            clk_s1_q <= dsclk_i;
            clk_s2_q <= clk_s1_q;
            clk_s3_q <= clk_s2_q;
            dat_s1_q <= dsi_i;
            dat_s2_q <= dat_s1_q;
        end
    end

    assign rise = clk_s2_q & ~clk_s3_q;
    assign fall = ~clk_s2_q & clk_s3_q;

    // ------------------------------------------------------------
    // shifting, response latched at the first edge of a frame
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            cnt_q      <= '0;
            rx_sh_q    <= '0;
            tx_sh_q    <= '0;
            dso_o      <= 1'b0;
            rx_valid_o <= 1'b0;
            rx_word_o  <= '0;
        end else begin
            rx_valid_o <= 1'b0;
            if (rise) begin
                rx_sh_q <= {rx_sh_q[15:0], dat_s2_q};
                if (cnt_q == '0) begin
                    tx_sh_q <= tx_word_i[15:0];
                end
                if (cnt_q == `DBGMC_FRAME_BITS - 5'h01) begin
                    cnt_q      <= '0;
                    rx_valid_o <= 1'b1;
                    rx_word_o  <= {rx_sh_q[14:0], dat_s2_q};
                end else begin
                    cnt_q <= cnt_q + 5'h01;
                end
            end else if (fall && cnt_q != '0) begin
                dso_o   <= tx_sh_q[15];
                tx_sh_q <= {tx_sh_q[14:0], 1'b0};
            end else if (cnt_q == '0) begin
                dso_o <= tx_word_i[16];
            end
        end
    end

endmodule : dbgmc_serial

// ---- src/dbgmc_core.sv ----
// debug port command logic for register writes and memory access
`timescale 1ns/1ns
`include "dbgmc_cfg.svh"
module dbgmc_core
    import dbgmc_pkg::*;
(
    // clock and reset
    input  wire logic        core_clk_i,
    input  wire logic        sys_rst_i,
    // serial link pins
    input  wire logic        dsclk_i,
    input  wire logic        dsi_i,
    output logic             dso_o,
    // halted core
    input  wire logic        cpu_halted_i,
    output logic             reg_wr_o,
    output logic [3:0]       reg_sel_o,
    output logic [31:0]      reg_wdata_o,
    output logic             resume_o,
    // debug address attribute
    input  wire logic [1:0]  transfer_type_field_i,
    input  wire logic [2:0]  transfer_modifier_field_i,
    // memory bus
    output logic             mem_req_o,
    output logic             mem_we_o,
    output logic [31:0]      mem_addr_o,
    output dbgmc_size_t      mem_size_o,
    output logic [31:0]      mem_wdata_o,
    output logic [1:0]       mem_tt_o,
    output logic [2:0]       mem_tm_o,
    input  wire logic        mem_ack_i,
    input  wire logic        mem_berr_i,
    input  wire logic [31:0] mem_rdata_i
);

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] f_inc(input dbgmc_size_t s);
        case (s)
            DBGMC_SZ_BYTE: f_inc = 32'h0000_0001;
            DBGMC_SZ_WORD: f_inc = 32'h0000_0002;
            default:       f_inc = 32'h0000_0004;
        endcase
    endfunction : f_inc

    function automatic logic [31:0] f_align(input logic [31:0] a,
                                            input dbgmc_size_t s);
        case (s)
            DBGMC_SZ_WORD: f_align = {a[31:1], 1'b0};
            DBGMC_SZ_LONG: f_align = {a[31:2], 2'b00};
            default:       f_align = a;
        endcase
    endfunction : f_align

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    dbgmc_state_e st_q;
    dbgmc_kind_e  kind_q;
    dbgmc_size_t  size_q;
    logic [16:0]  resp_q;
    logic [63:0]  ext_q;
    logic [1:0]   need_q;
    logic [31:0]  tmp_q;
    logic [15:0]  lo_q;
    logic         dump_ok_q;
    logic         fill_ok_q;
    logic         rx_valid;
    logic [15:0]  rx_word;

    // ------------------------------------------------------------
    // serial shifter
    // ------------------------------------------------------------
    dbgmc_serial u_serial (
        .core_clk_i (core_clk_i),
        .sys_rst_i  (sys_rst_i),
        .dsclk_i    (dsclk_i),
        .dsi_i      (dsi_i),
        .dso_o      (dso_o),
        .tx_word_i  (resp_q),
        .rx_valid_o (rx_valid),
        .rx_word_o  (rx_word)
    );

    // ------------------------------------------------------------
    // command decode
    // ------------------------------------------------------------
    logic        take_cmd;
    dbgmc_size_t cmd_sz;
    logic        sz_ok;
    logic        is_nop, is_go, is_wreg, is_read;
    logic        is_write, is_dump, is_fill;
    logic        last_op;
    logic [63:0] ext_n;
    logic [31:0] op_addr;
    logic [31:0] op_data;
    logic        mem_done;

    assign take_cmd = rx_valid && st_q == ST_CMD;
    assign cmd_sz   = rx_word[`DBGMC_SIZE_HI:`DBGMC_SIZE_LO];
    assign sz_ok    = cmd_sz != DBGMC_SZ_RSVD;
    assign is_nop   = rx_word == `DBGMC_CMD_NOP;
    assign is_go    = rx_word == `DBGMC_CMD_GO;
    assign is_wreg  = rx_word[15:8] == `DBGMC_OP_WREG &&
                      rx_word[7:4] == `DBGMC_OP_WREG_SUB;
    assign is_read  = rx_word[15:8] == `DBGMC_OP_READ && sz_ok;
    assign is_write = rx_word[15:8] == `DBGMC_OP_WRITE && sz_ok;
    assign is_dump  = rx_word[15:8] == `DBGMC_OP_DUMP && sz_ok;
    assign is_fill  = rx_word[15:8] == `DBGMC_OP_FILL && sz_ok;
    assign last_op  = rx_valid && st_q == ST_OPND && need_q == 2'h1;
    assign ext_n    = {ext_q[47:0], rx_word};
    assign mem_done = mem_req_o && (mem_ack_i || mem_berr_i);

    always_comb begin
        op_addr = ext_n[31:0];
        op_data = {16'h0000, ext_n[15:0]};
        if (size_q == DBGMC_SZ_LONG) begin
            op_data = ext_n[31:0];
        end
        case (kind_q)
            K_WRITE: begin
                op_addr = (size_q == DBGMC_SZ_LONG) ? ext_n[63:32]
                                                    : ext_n[47:16];
            end
            K_FILL:  op_addr = tmp_q;
            default: op_addr = ext_n[31:0];
        endcase
    end

    // ------------------------------------------------------------
    // sequencer and responses
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            st_q   <= ST_CMD;
            kind_q <= K_WREG;
            size_q <= DBGMC_SZ_BYTE;
            resp_q <= `DBGMC_RSP_DONE;
            need_q <= 2'h0;
            lo_q   <= '0;
        end else begin
            case (st_q)
                ST_CMD: if (rx_valid) begin
                    size_q <= cmd_sz;
                    if (is_nop || is_go) begin
                        resp_q <= `DBGMC_RSP_DONE;
                    end else if (is_wreg) begin
                        kind_q <= K_WREG;
                        need_q <= 2'h2;
                        st_q   <= ST_OPND;
                        resp_q <= `DBGMC_RSP_NRDY;
                    end else if (is_read) begin
                        kind_q <= K_READ;
                        need_q <= 2'h2;
                        st_q   <= ST_OPND;
                        resp_q <= `DBGMC_RSP_NRDY;
                    end else if (is_write) begin
                        kind_q <= K_WRITE;
                        need_q <= (cmd_sz == DBGMC_SZ_LONG) ? 2'h0
                                                            : 2'h3;
                        st_q   <= ST_OPND;
                        resp_q <= `DBGMC_RSP_NRDY;
                    end else if (is_dump && dump_ok_q) begin
                        kind_q <= K_DUMP;
                        st_q   <= ST_MEM;
                        resp_q <= `DBGMC_RSP_NRDY;
                    end else if (is_fill && fill_ok_q) begin
                        kind_q <= K_FILL;
                        need_q <= (cmd_sz == DBGMC_SZ_LONG) ? 2'h2
                                                            : 2'h1;
                        st_q   <= ST_OPND;
                        resp_q <= `DBGMC_RSP_NRDY;
                    end else begin
                        resp_q <= `DBGMC_RSP_ILL;
                    end
                end
                ST_OPND: if (rx_valid) begin
                    need_q <= need_q - 2'h1;
                    if (need_q == 2'h1) begin
                        if (kind_q != K_WREG) begin
                            st_q <= ST_MEM;
                        end else begin
                            st_q <= ST_CMD;
                            resp_q <= cpu_halted_i ? `DBGMC_RSP_DONE
                                                   : `DBGMC_RSP_BERR;
                        end
                    end
                end
                ST_MEM: if (mem_done) begin
                    st_q <= ST_CMD;
                    if (mem_berr_i) begin
                        resp_q <= `DBGMC_RSP_BERR;
                    end else if (mem_we_o) begin
                        resp_q <= `DBGMC_RSP_DONE;
                    end else if (size_q == DBGMC_SZ_LONG) begin
                        resp_q <= {1'b0, mem_rdata_i[31:16]};
                        lo_q   <= mem_rdata_i[15:0];
                        st_q   <= ST_RES_LO;
                    end else if (size_q == DBGMC_SZ_WORD) begin
                        resp_q <= {1'b0, mem_rdata_i[15:0]};
                    end else begin
                        resp_q <= {9'h000, mem_rdata_i[7:0]};
                    end
                end
                ST_RES_LO: if (rx_valid) begin
                    resp_q <= {1'b0, lo_q};
                    st_q   <= ST_CMD;
                end
                default: st_q <= ST_CMD;
            endcase
        end
    end

    // ------------------------------------------------------------
    // operand collection
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            ext_q <= '0;
        end else if (rx_valid && st_q == ST_OPND) begin
            ext_q <= ext_n;
        end
    end

    // ------------------------------------------------------------
    // register write and resume
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            reg_wr_o    <= 1'b0;
            reg_sel_o   <= '0;
            reg_wdata_o <= '0;
            resume_o    <= 1'b0;
        end else begin
            reg_wr_o <= 1'b0;
            resume_o <= take_cmd && is_go && cpu_halted_i;
            if (take_cmd && is_wreg) begin
                reg_sel_o <= rx_word[3:0];
            end
            if (last_op && kind_q == K_WREG && cpu_halted_i) begin
                reg_wr_o    <= 1'b1;
                reg_wdata_o <= ext_n[31:0];
            end
        end
    end

    // ------------------------------------------------------------
    // memory access
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            mem_req_o   <= 1'b0;
            mem_we_o    <= 1'b0;
            mem_addr_o  <= '0;
            mem_size_o  <= DBGMC_SZ_BYTE;
            mem_wdata_o <= '0;
            mem_tt_o    <= '0;
            mem_tm_o    <= '0;
        end else if (mem_done) begin
            mem_req_o <= 1'b0;
        end else if ((take_cmd && is_dump && dump_ok_q) ||
                     (last_op && kind_q != K_WREG)) begin
            mem_req_o  <= 1'b1;
            mem_tt_o   <= transfer_type_field_i;
            mem_tm_o   <= transfer_modifier_field_i;
            if (st_q == ST_CMD) begin
                mem_we_o   <= 1'b0;
                mem_size_o <= cmd_sz;
                mem_addr_o <= f_align(tmp_q, cmd_sz);
            end else begin
                mem_we_o    <= kind_q == K_WRITE || kind_q == K_FILL;
                mem_size_o  <= size_q;
                mem_addr_o  <= f_align(op_addr, size_q);
                mem_wdata_o <= op_data;
            end
        end
    end

    // ------------------------------------------------------------
    // temporary address and block command permission
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            tmp_q <= '0;
        end else if (mem_done) begin
            tmp_q <= mem_addr_o + f_inc(mem_size_o);
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            dump_ok_q <= 1'b0;
            fill_ok_q <= 1'b0;
        end else if (take_cmd && !is_nop) begin
            dump_ok_q <= is_read || (is_dump && dump_ok_q);
            fill_ok_q <= is_write || (is_fill && fill_ok_q);
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (sys_rst_i);

    sequence s_mem_done;
        mem_req_o && (mem_ack_i || mem_berr_i);
    endsequence

    property p_wreg_halted;
        reg_wr_o |-> $past(cpu_halted_i);
    endproperty
    a_wreg_halted: assert property (p_wreg_halted)
        else $error("register written while core running");

    property p_write_done;
        s_mem_done ##0 (mem_we_o && !mem_berr_i)
            |=> resp_q == `DBGMC_RSP_DONE;
    endproperty
    a_write_done: assert property (p_write_done)
        else $error("write completion word wrong");

    property p_berr;
        s_mem_done ##0 mem_berr_i |=> resp_q == `DBGMC_RSP_BERR;
    endproperty
    a_berr: assert property (p_berr)
        else $error("bus error response wrong");

    property p_align;
        mem_req_o |-> (mem_size_o != DBGMC_SZ_WORD || !mem_addr_o[0]) &&
                      (mem_size_o != DBGMC_SZ_LONG ||
                       mem_addr_o[1:0] == 2'b00);
    endproperty
    a_align: assert property (p_align)
        else $error("memory address misaligned");

    property p_space;
        $rose(mem_req_o) |-> mem_tt_o == $past(transfer_type_field_i) &&
                             mem_tm_o == $past(transfer_modifier_field_i);
    endproperty
    a_space: assert property (p_space)
        else $error("address space not taken from attribute");

    property p_resume;
        resume_o |-> $past(cpu_halted_i) && $past(take_cmd);
    endproperty
    a_resume: assert property (p_resume)
        else $error("resume while core not halted");

    property p_not_ready;
        mem_req_o |-> resp_q == `DBGMC_RSP_NRDY;
    endproperty
    a_not_ready: assert property (p_not_ready)
        else $error("response not ready missing during access");

    property p_inc;
        s_mem_done |=> tmp_q == $past(mem_addr_o) + f_inc($past(mem_size_o));
    endproperty
    a_inc: assert property (p_inc)
        else $error("temporary address not advanced");

    property p_nop_keep;
        take_cmd && is_nop |=> $stable(tmp_q) && $stable(dump_ok_q);
    endproperty
    a_nop_keep: assert property (p_nop_keep)
        else $error("nop disturbed the block address");

    property p_dump_ill;
        take_cmd && is_dump && !dump_ok_q |=> resp_q == `DBGMC_RSP_ILL;
    endproperty
    a_dump_ill: assert property (p_dump_ill)
        else $error("illegal dump accepted");

endmodule : dbgmc_core

// ---- testbench/dbgmc_host_model.sv ----
// development system model driving the serial debug link
`timescale 1ns/1ns
module dbgmc_host_model (
    // clock
    input  wire logic core_clk_i,
    // link pins
    output logic      dsclk_o,
    output logic      dsi_o,
    input  wire logic dso_i
);
    initial begin
        dsclk_o = 1'b0;
        dsi_o   = 1'b0;
    end

    // one frame: word out msb first, previous response in
    task automatic xfer(input logic [15:0] w, output logic [16:0] r);
        logic [16:0] f;
        f = {1'b0, w};
        for (int i = 16; i >= 0; i--) begin
            dsi_o <= f[i];
            repeat (3) @(posedge core_clk_i);
            @(negedge core_clk_i);
            r[i] = dso_i;
            @(posedge core_clk_i);
            dsclk_o <= 1'b1;
            repeat (4) @(posedge core_clk_i);
            dsclk_o <= 1'b0;
        end
        // data line not held between frames
        dsi_o <= ~f[0];
        repeat (8) @(posedge core_clk_i);
    endtask : xfer
endmodule : dbgmc_host_model

// ---- testbench/tb_dbgmc_core.sv ----
// self-checking bench of the debug port command logic
`timescale 1ns/1ns
`include "dbgmc_cfg.svh"
module tb_dbgmc_core
    import dbgmc_pkg::*;
;
    // ----------
    // signals
    // ----------
    logic        core_clk_i, sys_rst_i, dsclk_i, dsi_i, dso_o, reg_wr_o;
    logic        cpu_halted_i, resume_o, mem_req_o, mem_we_o, mem_ack_i;
    logic        mem_berr_i, lwe, berr_en, go_m;
    logic [1:0]  transfer_type_field_i, mem_tt_o;
    logic [2:0]  transfer_modifier_field_i, mem_tm_o;
    logic [3:0]  reg_sel_o, wsel;
    logic [4:0]  lat;
    logic [16:0] rsp;
    logic [31:0] reg_wdata_o, mem_addr_o, mem_wdata_o, mem_rdata_i;
    logic [31:0] tmp, la, lwd, wdat, ex;
    dbgmc_size_t mem_size_o, lsz;
    int          stall = 0, wt = 0, n_acc = 0, n_wr = 0, n_res = 0;
    int          n_fail = 0, tests_run = 0;
    localparam logic [15:0] NOPW = `DBGMC_CMD_NOP;

    initial begin
        core_clk_i = 1'b0;
        forever #5 core_clk_i = ~core_clk_i;
    end
    dbgmc_host_model host (.core_clk_i, .dsclk_o(dsclk_i), .dsi_o(dsi_i),
                           .dso_i(dso_o));
    dbgmc_core DUT (.core_clk_i, .sys_rst_i, .dsclk_i, .dsi_i, .dso_o,
        .cpu_halted_i, .reg_wr_o, .reg_sel_o, .reg_wdata_o, .resume_o,
        .transfer_type_field_i, .transfer_modifier_field_i, .mem_req_o,
        .mem_we_o, .mem_addr_o, .mem_size_o, .mem_wdata_o, .mem_tt_o,
        .mem_tm_o, .mem_ack_i, .mem_berr_i, .mem_rdata_i);

    // ----------
    // memory bus and core models
    // ----------
    function automatic logic [31:0] pat(input logic [31:0] a);
        return {~a[31:16], a[15:0] ^ 16'hc3a5};
    endfunction : pat
    assign go_m = mem_req_o && !mem_ack_i && !mem_berr_i && wt >= stall;
    always @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            mem_ack_i   <= 1'b0;
            mem_berr_i  <= 1'b0;
            mem_rdata_i <= 32'h0000_0000;
        end else begin
            mem_ack_i   <= go_m & ~berr_en;
            mem_berr_i  <= go_m & berr_en;
            mem_rdata_i <= go_m ? pat(mem_addr_o) : ~mem_rdata_i;
        end
        wt          <= (mem_req_o && !go_m) ? wt + 1 : 0;
        if (go_m) begin
            {la, lsz, lwe, lwd} <= {mem_addr_o, mem_size_o, mem_we_o,
                                    mem_wdata_o};
            lat   <= {mem_tt_o, mem_tm_o};
            n_acc <= n_acc + 1;
        end
        if (reg_wr_o) begin
            n_wr <= n_wr + 1;
            wsel <= reg_sel_o;
            wdat <= reg_wdata_o;
        end
        if (resume_o) n_res <= n_res + 1;
    end

    // ----------
    // tasks
    // ----------
    task automatic report_and_stop;
        if (n_fail == 0 && tests_run > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : report_and_stop
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        tests_run++;
        if (g !== e) begin
            n_fail++;
            $display("CHECK FAILED at %0t got %h expected %h", $time, g, e);
        end
    endtask : chk
    task automatic xf(input logic [15:0] w);
        host.xfer(w, rsp);
    endtask : xf
    task automatic chr(input logic [16:0] e, input logic [16:0] m);
        chk({15'h0, rsp & m}, {15'h0, e & m});
    endtask : chr
    task automatic bad(input logic [15:0] w);
        int na;
        na = n_acc;
        xf(w);
        xf(NOPW);
        chr(`DBGMC_RSP_ILL, 17'h1_ffff);
        chk(32'(n_acc), 32'(na));
    endtask : bad
    task automatic wreg(input logic h);
        logic [31:0] d;
        logic [3:0]  sel;
        int          nw;
        d  = $urandom;
        sel = 4'($urandom);
        nw = n_wr;
        cpu_halted_i <= h;
        xf({`DBGMC_OP_WREG, `DBGMC_OP_WREG_SUB, sel});
        xf(d[31:16]);
        xf(d[15:0]);
        xf(NOPW);
        chr(h ? `DBGMC_RSP_DONE : `DBGMC_RSP_BERR, 17'h1_ffff);
        chk(32'(n_wr - nw), 32'(h));
        if (h) chk(wdat, d);
        if (h) chk({28'h0, wsel}, {28'h0, sel});
    endtask : wreg
    task automatic go(input logic h);
        int nr;
        nr = n_res;
        cpu_halted_i <= h;
        xf(`DBGMC_CMD_GO);
        xf(NOPW);
        chr(`DBGMC_RSP_DONE, 17'h1_ffff);
        chk(32'(n_res - nr), 32'(h));
    endtask : go
    task automatic mop(input logic [7:0] op, input dbgmc_size_t s,
                       input logic [31:0] a, input logic [31:0] d,
                       input logic be);
        logic [31:0] ea, wm;
        logic [16:0] m;
        int          na;
        na = n_acc;
        berr_en <= be;
        stall <= $urandom_range(3);
        transfer_type_field_i <= 2'($urandom);
        transfer_modifier_field_i <= 3'($urandom);
        xf({op, s, 6'h00});
        if (!op[2]) begin
            xf(a[31:16]);
            xf(a[15:0]);
            tmp = a;
        end
        if (!op[0] && s == DBGMC_SZ_LONG) xf(d[31:16]);
        if (!op[0]) xf(d[15:0]);
        ea = tmp & ~((32'h1 << s) - 32'h1);
        wm = ~(32'hffff_ffff << (8 << s));
        ex = be ? 32'h0001_0001 : (op[0] ? pat(ea) : 32'h0000_ffff);
        m = (op[0] && s == DBGMC_SZ_BYTE) ? 17'h1_00ff : 17'h1_ffff;
        xf(NOPW);
        if (!be && op[0] && s == DBGMC_SZ_LONG) begin
            chr({1'b0, ex[31:16]}, m);
            xf(NOPW);
        end
        chr({be, ex[15:0]}, m);
        chk(32'(n_acc - na), 32'h1);
        chk(la, ea);
        chk({lwe, lat, 24'h0, lsz}, {~op[0], transfer_type_field_i,
            transfer_modifier_field_i, 24'h0, s});
        if (!op[0]) chk(lwd & wm, d & wm);
        tmp = ea + (32'h1 << s);
    endtask : mop

    // ----------
    // sequence
    // ----------
    initial begin
        #900_000;
        n_fail++;
        report_and_stop;
    end
    initial begin
        logic [7:0] o;
        void'($urandom(32'h2a2f));
        {sys_rst_i, cpu_halted_i} = 2'b11;
        {transfer_type_field_i, transfer_modifier_field_i, berr_en} = 6'h00;
        repeat (3) @(posedge core_clk_i);
        sys_rst_i <= 1'b0;
        repeat (4) @(posedge core_clk_i);
        bad({`DBGMC_OP_DUMP, 8'h00});
        bad({`DBGMC_OP_FILL, 8'h00});
        wreg(1'b1);
        wreg(1'b0);
        go(1'b0);
        go(1'b1);
        bad({`DBGMC_OP_READ, 8'hc0});
        for (int i = 0; i < 12; i++) begin
            mop(`DBGMC_OP_READ, 2'(i % 3), $urandom, 0, i == 7);
            mop(`DBGMC_OP_WRITE, 2'(i % 3), $urandom, $urandom, i[0]);
        end
        for (int c = 0; c < 2; c++) begin
            o = c ? `DBGMC_OP_WRITE : `DBGMC_OP_READ;
            mop(o, DBGMC_SZ_LONG, 32'hffff_fff4, $urandom, 1'b0);
            for (int k = 0; k < 6; k++)
                mop(o | 8'h04, k < 2 ? DBGMC_SZ_LONG : 2'($urandom_range(2)),
                    0, $urandom, k == 5);
            bad({o ^ 8'h05, 8'h00});
        end
        // slow memory: frames during the access are refused
        berr_en <= 1'b0;
        stall <= 100000;
        ex = pat(32'h0000_0102);
        xf(16'h1940);
        xf(16'h0000);
        xf(16'h0103);
        xf(NOPW);
        chr(`DBGMC_RSP_NRDY, 17'h1_ffff);
        xf(NOPW);
        chr(`DBGMC_RSP_NRDY, 17'h1_ffff);
        stall <= 0;
        repeat (8) @(posedge core_clk_i);
        xf(NOPW);
        chr({1'b0, ex[15:0]}, 17'h1_ffff);
        report_and_stop;
    end
endmodule : tb_dbgmc_core
